// *** src/xgpc_pkg.sv ***
// package for the xgmii port and configuration port block
// assumes a single 50 MHz clock shared by both ends
package xgpc_pkg;

  // ************************************************
  // xgmii lane layout
  // ************************************************
  localparam int XGPC_LANES      = 8;
  localparam int XGPC_LANE_W     = 9;
  localparam int XGPC_BUS_W      = 72;
  localparam int XGPC_DATA_W     = 8;
  localparam int XGPC_CTRL_BIT   = 8;

  localparam logic [7:0] XGPC_CH_IDLE  = 8'h07;
  localparam logic [7:0] XGPC_CH_START = 8'hFB;
  localparam logic [7:0] XGPC_CH_TERM  = 8'hFD;
  localparam logic [7:0] XGPC_CH_ERROR = 8'hFE;
  localparam logic [7:0] XGPC_CH_SEQ   = 8'h9C;
  localparam logic [7:0] XGPC_FAULT_LOCAL  = 8'h01;
  localparam logic [7:0] XGPC_FAULT_REMOTE = 8'h02;

  // ************************************************
  // link fault encoding
  // ************************************************
  typedef enum logic [1:0] {
    XGPC_FLT_NONE   = 2'h0,
    XGPC_FLT_LOCAL  = 2'h1,
    XGPC_FLT_REMOTE = 2'h2
  } xgpc_fault_t;

  // ************************************************
  // receive error vector layout
  // ************************************************
  localparam int XGPC_RXERR_W   = 6;
  localparam int XGPC_RXERR_PHY = 0;

  // ************************************************
  // configuration port
  // ************************************************
  localparam int XGPC_ADDR_W = 13;
  localparam int XGPC_CFG_W  = 32;
  localparam int XGPC_CFG_WORDS = 16;
  localparam logic [31:0] XGPC_CFG_RESET = 32'h0000_0000;
  localparam logic [2:0]  XGPC_ACC_CYCLES = 3'h2;
  localparam logic [31:0] XGPC_UNMAPPED = 32'h0000_0000;

endpackage

// *** src/xgpc_if.sv ***
// interface joining the device end and the partner end
// assumes both ends run on sys_clk
`timescale 1ns/10ps
`default_nettype none
interface xgpc_if
  import xgpc_pkg::*;
(
  input wire logic sys_clk
);
  logic [XGPC_BUS_W-1:0]  rx_bus;
  logic [XGPC_BUS_W-1:0]  tx_bus;
  logic [1:0]             fault_to_tx;
  logic [1:0]             fault_from_rx;
  logic [XGPC_ADDR_W-1:0] cfg_addr;
  logic                   cfg_rd;
  logic                   cfg_wr;
  logic [XGPC_CFG_W-1:0]  cfg_wdata;
  logic [XGPC_CFG_W-1:0]  cfg_rdata;
  logic                   cfg_wait;

  modport dev (
    input  rx_bus, fault_to_tx, cfg_addr, cfg_rd, cfg_wr, cfg_wdata,
    output tx_bus, fault_from_rx, cfg_rdata, cfg_wait
  );
  modport far (
    output rx_bus, fault_to_tx, cfg_addr, cfg_rd, cfg_wr, cfg_wdata,
    input  tx_bus, fault_from_rx, cfg_rdata, cfg_wait
  );
endinterface
`default_nettype wire

// *** src/xgpc_dev.sv ***
// device end: xgmii tx/rx reconciliation and configuration port slave
// assumes the partner keeps request fields stable while cfg_wait is high
`timescale 1ns/10ps
`default_nettype none

module xgpc_dev
  import xgpc_pkg::*;
(
  // clock and reset
  input  wire logic                    sys_clk,
  input  wire logic                    srst,
  // link
  xgpc_if.dev                          lnk,
  // transmit client
  input  wire logic                    tx_valid,
  input  wire logic [63:0]             tx_data,
  input  wire logic                    tx_sop,
  input  wire logic                    tx_eop,
  input  wire logic                    tx_err,
  input  wire logic                    tx_fault_ext_en,
  // receive client
  output logic                         rx_valid,
  output logic [63:0]                  rx_data,
  output logic [XGPC_RXERR_W-1:0]      client_receive_error_vector,
  output logic [1:0]                   rx_fault,
  output logic [1:0]                   tx_fault_seen
);

  // ************************************************
  // lane helpers
  // ************************************************
  function automatic logic [8:0] lane_of(input logic [71:0] bus, input int idx);
    lane_of = bus[idx*XGPC_LANE_W +: XGPC_LANE_W];
  endfunction

  function automatic logic lane_is_err(input logic [8:0] ln);
    lane_is_err = ln[XGPC_CTRL_BIT] && (ln[7:0] == XGPC_CH_ERROR);
  endfunction

  function automatic logic [7:0] lane_dat(input logic [71:0] bus, input int idx);
    lane_dat = bus[idx*XGPC_LANE_W +: XGPC_DATA_W];
  endfunction

  // ************************************************
  // transmit side
  // ************************************************
  logic [71:0] tx_q;
  logic [71:0] tx_d;
  logic [1:0]  fault_sel;

  // tx-only builds take the external fault code; otherwise the rx half feeds it
  assign fault_sel = tx_fault_ext_en ? lnk.fault_to_tx : rx_fault;

  always_comb
  begin
    tx_d = '0;
    for (int i = 0; i < XGPC_LANES; i++)
      tx_d[i*XGPC_LANE_W +: XGPC_LANE_W] = {1'b1, XGPC_CH_IDLE};
    if (fault_sel == XGPC_FLT_LOCAL || fault_sel == XGPC_FLT_REMOTE)
    begin
      // answer a fault with remote fault sequence ordered sets
      tx_d[8:0]   = {1'b1, XGPC_CH_SEQ};
      tx_d[35:27] = {1'b0, XGPC_FAULT_REMOTE};
    end
    else if (tx_valid)
    begin
      for (int i = 0; i < XGPC_LANES; i++)
      begin
        if (tx_err)
        begin
          tx_d[i*XGPC_LANE_W +: XGPC_LANE_W] = {1'b1, XGPC_CH_ERROR};
        end
        else
        begin
          tx_d[i*XGPC_LANE_W +: XGPC_LANE_W] = {1'b0, tx_data[i*8 +: 8]};
        end
      end
      // passthrough: client byte 0 replaced by start, bytes 1..7 are preamble
      if (tx_sop && !tx_err)
        tx_d[8:0] = {1'b1, XGPC_CH_START};
      if (tx_eop && !tx_err)
        tx_d[71:63] = {1'b1, XGPC_CH_TERM};
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      tx_q <= {XGPC_LANES{1'b1, XGPC_CH_IDLE}};
    else
      tx_q <= tx_d;
  end

  assign lnk.tx_bus = tx_q;

  // ************************************************
  // receive side
  // ************************************************
  logic        rx_valid_q, rx_valid_d;
  logic [63:0] rx_data_q, rx_data_d;
  logic [XGPC_RXERR_W-1:0] rx_err_q, rx_err_d;
  logic [1:0]  rx_fault_q, rx_fault_d;
  logic [1:0]  tx_fault_q;
  logic        any_ctrl;

  always_comb
  begin
    rx_data_d  = '0;
    rx_err_d   = '0;
    rx_fault_d = rx_fault_q;
    any_ctrl   = 1'b0;
    for (int i = 0; i < XGPC_LANES; i++)
    begin
      rx_data_d[i*8 +: 8] = lane_dat(lnk.rx_bus, i);
      if (lnk.rx_bus[i*XGPC_LANE_W + XGPC_CTRL_BIT])
        any_ctrl = 1'b1;
      if (lane_is_err(lane_of(lnk.rx_bus, i)))
        rx_err_d[XGPC_RXERR_PHY] = 1'b1;
    end
    rx_valid_d = !any_ctrl || rx_err_d[XGPC_RXERR_PHY];
    if (lane_of(lnk.rx_bus, 0) == {1'b1, XGPC_CH_SEQ})
    begin
      if (lane_dat(lnk.rx_bus, 3) == XGPC_FAULT_LOCAL)
        rx_fault_d = XGPC_FLT_LOCAL;
      else if (lane_dat(lnk.rx_bus, 3) == XGPC_FAULT_REMOTE)
        rx_fault_d = XGPC_FLT_REMOTE;
      else
        rx_fault_d = XGPC_FLT_NONE;
    end
    else if (!any_ctrl || lane_of(lnk.rx_bus, 0) == {1'b1, XGPC_CH_START})
      rx_fault_d = XGPC_FLT_NONE;
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      rx_valid_q <= 1'b0;
      rx_data_q  <= '0;
      rx_err_q   <= '0;
      rx_fault_q <= XGPC_FLT_NONE;
      tx_fault_q <= XGPC_FLT_NONE;
    end
    else
    begin
      rx_valid_q <= rx_valid_d;
      rx_data_q  <= rx_data_d;
      rx_err_q   <= rx_err_d;
      rx_fault_q <= rx_fault_d;
      tx_fault_q <= fault_sel;
    end
  end

  assign rx_valid = rx_valid_q;
  assign rx_data  = rx_data_q;
  assign client_receive_error_vector = rx_err_q;
  assign rx_fault = rx_fault_q;
  assign tx_fault_seen = tx_fault_q;
  assign lnk.fault_from_rx = rx_fault_q;

  // ************************************************
  // configuration port
  // ************************************************
  typedef enum logic [2:0] {
    XGPC_CS_IDLE = 3'b001,
    XGPC_CS_BUSY = 3'b010,
    XGPC_CS_DONE = 3'b100
  } xgpc_cs_t;

  xgpc_cs_t    cs_q, cs_d;
  logic [2:0]  cnt_q, cnt_d;
  logic        wait_q, wait_d;
  logic [31:0] rdata_q, rdata_d;
  logic [31:0] regs_q [XGPC_CFG_WORDS];
  logic        wr_en;
  logic [3:0]  widx;

  assign widx = lnk.cfg_addr[3:0];

  always_comb
  begin
    cs_d    = cs_q;
    cnt_d   = cnt_q;
    wait_d  = wait_q;
    rdata_d = rdata_q;
    wr_en   = 1'b0;
    case (cs_q)
      XGPC_CS_IDLE:
      begin
        if (lnk.cfg_rd || lnk.cfg_wr)
        begin
          cs_d  = XGPC_CS_BUSY;
          cnt_d = XGPC_ACC_CYCLES;
        end
      end
      XGPC_CS_BUSY:
      begin
        // request held by host while waiting
        cnt_d = cnt_q - 3'h1;
        if (cnt_q == 3'h1)
        begin
          cs_d   = XGPC_CS_DONE;
          wait_d = 1'b0;
          if (lnk.cfg_rd)
          begin
            rdata_d = (lnk.cfg_addr < XGPC_ADDR_W'(XGPC_CFG_WORDS)) ?
                      regs_q[widx] : XGPC_UNMAPPED;
          end
          wr_en = lnk.cfg_wr &&
                  (lnk.cfg_addr < XGPC_ADDR_W'(XGPC_CFG_WORDS));
        end
      end
      XGPC_CS_DONE:
      begin
        cs_d   = XGPC_CS_IDLE;
        wait_d = 1'b1;
      end
      default:
      begin
        cs_d   = XGPC_CS_IDLE;
        wait_d = 1'b1;
      end
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      cs_q    <= XGPC_CS_IDLE;
      cnt_q   <= 3'h0;
      wait_q  <= 1'b1;
      rdata_q <= XGPC_CFG_RESET;
      for (int i = 0; i < XGPC_CFG_WORDS; i++)
      begin
        regs_q[i] <= XGPC_CFG_RESET;
      end
    end
    else
    begin
      cs_q    <= cs_d;
      cnt_q   <= cnt_d;
      wait_q  <= wait_d;
      rdata_q <= rdata_d;
      if (wr_en)
      begin
        regs_q[widx] <= lnk.cfg_wdata;
      end
    end
  end

  assign lnk.cfg_rdata = rdata_q;
  assign lnk.cfg_wait  = wait_q;

endmodule
`default_nettype wire

// *** src/xgpc_far.sv ***
// partner end: phy-side lane driver and configuration host
// assumes the device end answers with cfg_wait low for one cycle
`timescale 1ns/10ps
`default_nettype none
module xgpc_far
  import xgpc_pkg::*;
(
  // clock and reset
  input  wire logic                    sys_clk,
  input  wire logic                    srst,
  // link
  xgpc_if.far                          lnk,
  // phy-side user
  input  wire logic [63:0]             phy_data,
  input  wire logic [7:0]              phy_ctrl,
  input  wire logic [7:0]              phy_err,
  input  wire logic [1:0]              fault_drive,
  // command port
  input  wire logic                    cmd_go,
  input  wire logic                    cmd_wr,
  input  wire logic [XGPC_ADDR_W-1:0]  cmd_addr,
  input  wire logic [31:0]             cmd_wdata,
  output logic                         cmd_busy,
  output logic                         cmd_done,
  output logic [31:0]                  cmd_rdata
);

  // ************************************************
  // lane driver
  // ************************************************
  logic [71:0] rx_q, rx_d;
  logic [1:0]  flt_q;

  always_comb
  begin
    rx_d = '0;
    for (int i = 0; i < XGPC_LANES; i++)
    begin
      if (phy_err[i])
      begin
        rx_d[i*XGPC_LANE_W +: XGPC_LANE_W] = {1'b1, XGPC_CH_ERROR};
      end
      else
      begin
        rx_d[i*XGPC_LANE_W +: XGPC_LANE_W] = {phy_ctrl[i], phy_data[i*8 +: 8]};
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      rx_q  <= {XGPC_LANES{1'b1, XGPC_CH_IDLE}};
      flt_q <= XGPC_FLT_NONE;
    end
    else
    begin
      rx_q  <= rx_d;
      flt_q <= fault_drive;
    end
  end

  assign lnk.rx_bus      = rx_q;
  assign lnk.fault_to_tx = flt_q;

  // ************************************************
  // configuration host
  // ************************************************
  logic                   act_q, act_d;
  logic                   rd_q, rd_d, wr_q, wr_d;
  logic [XGPC_ADDR_W-1:0] addr_q, addr_d;
  logic [31:0]            wd_q, wd_d, rd_data_q, rd_data_d;
  logic                   done_q, done_d;

  always_comb
  begin
    act_d     = act_q;
    rd_d      = rd_q;
    wr_d      = wr_q;
    addr_d    = addr_q;
    wd_d      = wd_q;
    rd_data_d = rd_data_q;
    done_d    = 1'b0;
    if (!act_q && cmd_go)
    begin
      act_d  = 1'b1;
      rd_d   = !cmd_wr;
      wr_d   = cmd_wr;
      addr_d = cmd_addr;
      wd_d   = cmd_wdata;
    end
    else if (act_q && !lnk.cfg_wait)
    begin
      // fields held until wait drops
      act_d  = 1'b0;
      rd_d   = 1'b0;
      wr_d   = 1'b0;
      done_d = 1'b1;
      if (rd_q)
      begin
        rd_data_d = lnk.cfg_rdata;
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      act_q     <= 1'b0;
      rd_q      <= 1'b0;
      wr_q      <= 1'b0;
      addr_q    <= '0;
      wd_q      <= '0;
      rd_data_q <= '0;
      done_q    <= 1'b0;
    end
    else
    begin
      act_q     <= act_d;
      rd_q      <= rd_d;
      wr_q      <= wr_d;
      addr_q    <= addr_d;
      wd_q      <= wd_d;
      rd_data_q <= rd_data_d;
      done_q    <= done_d;
    end
  end

  assign lnk.cfg_rd    = rd_q;
  assign lnk.cfg_wr    = wr_q;
  assign lnk.cfg_addr  = addr_q;
  assign lnk.cfg_wdata = wd_q;
  assign cmd_busy      = act_q;
  assign cmd_done      = done_q;
  assign cmd_rdata     = rd_data_q;

endmodule
`default_nettype wire

// *** sim/xgpc_properties.sv ***
// concurrent checks on the link between the device end and the partner end
// assumes one instance beside xgpc_if in the bench top, single sys_clk domain
`timescale 1ns/10ps
`default_nettype none
module xgpc_properties
  import xgpc_pkg::*;
(
  // clock and reset
  input wire logic                   sys_clk,
  input wire logic                   srst,
  // xgmii lanes and fault codes
  input wire logic [XGPC_BUS_W-1:0]  rx_bus,
  input wire logic [XGPC_BUS_W-1:0]  tx_bus,
  input wire logic [1:0]             fault_to_tx,
  input wire logic [1:0]             fault_from_rx,
  // configuration port
  input wire logic [XGPC_ADDR_W-1:0] cfg_addr,
  input wire logic                   cfg_rd,
  input wire logic                   cfg_wr,
  input wire logic [XGPC_CFG_W-1:0]  cfg_wdata,
  input wire logic [XGPC_CFG_W-1:0]  cfg_rdata,
  input wire logic                   cfg_wait
);
  logic tx_bad;

  // ************************************************
  // control lanes carrying an unknown character
  // ************************************************
  always_comb
  begin
    tx_bad = 1'b0;
    for (int i = 0; i < XGPC_LANES; i++)
    begin
      if (tx_bus[i*XGPC_LANE_W+XGPC_CTRL_BIT] && !(tx_bus[i*XGPC_LANE_W+:8] inside
          {XGPC_CH_IDLE, XGPC_CH_START, XGPC_CH_TERM, XGPC_CH_ERROR, XGPC_CH_SEQ}))
      begin
        tx_bad = 1'b1;
      end
    end
  end

  // ************************************************
  // assertions
  // ************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  fault_code_a:
    assert property (fault_from_rx != 2'h3) else $error("illegal fault code");
  local_fault_a:
    assert property (rx_bus[8:0] == 9'h19C && rx_bus[35:27] == {1'b0, XGPC_FAULT_LOCAL}
      |=> fault_from_rx == XGPC_FLT_LOCAL) else $error("local fault not reported");
  remote_fault_a:
    assert property (rx_bus[8:0] == 9'h19C && rx_bus[35:27] == {1'b0, XGPC_FAULT_REMOTE}
      |=> fault_from_rx == XGPC_FLT_REMOTE) else $error("remote fault not reported");
  fault_clear_a:
    assert property (rx_bus[8:0] == {1'b1, XGPC_CH_START} |=> fault_from_rx == XGPC_FLT_NONE)
      else $error("fault not cleared by start");
  tx_lane_legal_a:
    assert property (!tx_bad) else $error("unknown control character on tx lane");
  wait_pulse_a:
    assert property (!cfg_wait |=> cfg_wait) else $error("wait low longer than one cycle");
  wait_cause_a:
    assert property (!cfg_wait |-> $past(cfg_rd || cfg_wr)) else $error("wait low without request");
  wait_bound_a:
    assert property ($rose(cfg_rd || cfg_wr) |-> ##[1:4] !cfg_wait) else $error("access never ends");
  rdata_hold_a:
    assert property ($changed(cfg_rdata) |-> cfg_rd && !cfg_wait) else $error("read data moved");

  rd_done_c: cover property (!cfg_wait && cfg_rd);
  wr_done_c: cover property (!cfg_wait && cfg_wr);
  remote_c:  cover property (fault_from_rx == XGPC_FLT_REMOTE);
endmodule
`default_nettype wire

// *** sim/tb_xgpc.sv ***
// self-checking bench: device end facing partner end across xgpc_if
// assumes 50 MHz sys_clk and synchronous active-high srst
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_fail++; \
  $display("Error t=%0t got %h exp %h", $time, (a), (e)); end end
module tb_xgpc;
  import xgpc_pkg::*;
  logic        sys_clk, srst, tx_valid, tx_sop, tx_eop, tx_err, tx_fault_ext_en;
  logic        cmd_go, cmd_wr, cmd_busy, cmd_done, rx_valid;
  logic [63:0] tx_data, phy_data, rx_data;
  logic [7:0]  phy_ctrl, phy_err;
  logic [1:0]  fault_drive, rx_fault, tx_fault_seen;
  logic [12:0] cmd_addr;
  logic [31:0] cmd_wdata, cmd_rdata, rd;
  logic [5:0]  rx_err_vec;
  int          n_fail, n_checks;

  xgpc_if xgpc_if_i (.sys_clk(sys_clk));
  xgpc_dev xgpc_dev_i (.sys_clk(sys_clk), .srst(srst), .lnk(xgpc_if_i), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_sop(tx_sop), .tx_eop(tx_eop), .tx_err(tx_err),
    .tx_fault_ext_en(tx_fault_ext_en), .rx_valid(rx_valid), .rx_data(rx_data),
    .client_receive_error_vector(rx_err_vec), .rx_fault(rx_fault), .tx_fault_seen(tx_fault_seen));
  xgpc_far xgpc_far_i (.sys_clk(sys_clk), .srst(srst), .lnk(xgpc_if_i), .phy_data(phy_data),
    .phy_ctrl(phy_ctrl), .phy_err(phy_err), .fault_drive(fault_drive), .cmd_go(cmd_go),
    .cmd_wr(cmd_wr), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_busy(cmd_busy),
    .cmd_done(cmd_done), .cmd_rdata(cmd_rdata));
  xgpc_properties xgpc_properties_i (.sys_clk(sys_clk), .srst(srst), .rx_bus(xgpc_if_i.rx_bus),
    .tx_bus(xgpc_if_i.tx_bus), .fault_to_tx(xgpc_if_i.fault_to_tx),
    .fault_from_rx(xgpc_if_i.fault_from_rx), .cfg_addr(xgpc_if_i.cfg_addr),
    .cfg_rd(xgpc_if_i.cfg_rd), .cfg_wr(xgpc_if_i.cfg_wr), .cfg_wdata(xgpc_if_i.cfg_wdata),
    .cfg_rdata(xgpc_if_i.cfg_rdata), .cfg_wait(xgpc_if_i.cfg_wait));

  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // ************************************************
  // helpers
  // ************************************************
  function automatic logic [71:0] lanes(input logic [63:0] d, input logic [7:0] c);
    for (int i = 0; i < 8; i++)
    begin
      lanes[i*9+:9] = {c[i], d[i*8+:8]};
    end
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic give_verdict;
    if (n_fail == 0 && n_checks > 0)
    begin
      $display("Run complete: PASS");
    end
    else
    begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic cfg_acc(input logic w, input logic [12:0] a, input logic [31:0] d);
    int k;
    @(posedge sys_clk);
    cmd_go <= 1'b1;
    cmd_wr <= w;
    cmd_addr <= a;
    cmd_wdata <= d;
    @(posedge sys_clk);
    cmd_go <= 1'b0;
    #1;
    `CHK(cmd_busy, 1'b1)
    for (k = 0; k < 20 && cmd_done !== 1'b1; k++)
    begin
      cyc(1);
    end
    if (k == 20)
    begin
      n_fail++;
      give_verdict();
    end
    rd = cmd_rdata;
  endtask

  // ************************************************
  // scenarios
  // ************************************************
  task automatic t_tx;
    @(posedge sys_clk);
    tx_valid <= 1'b1;
    tx_sop <= 1'b1;
    tx_data <= 64'hD555_5555_5555_55AA;
    cyc(1);
    `CHK(xgpc_if_i.tx_bus, lanes(64'hD555_5555_5555_55FB, 8'h01))
    @(posedge sys_clk);
    tx_sop <= 1'b0;
    tx_eop <= 1'b1;
    tx_data <= 64'h0807_0605_0403_0201;
    cyc(1);
    `CHK(xgpc_if_i.tx_bus, lanes(64'hFD07_0605_0403_0201, 8'h80))
    @(posedge sys_clk);
    tx_err <= 1'b1;
    cyc(1);
    `CHK(xgpc_if_i.tx_bus, {8{9'h1FE}})
    @(posedge sys_clk);
    {tx_valid, tx_eop, tx_err} <= 3'h0;
  endtask

  task automatic t_rx;
    @(posedge sys_clk);
    phy_data <= 64'h8877_6655_4433_2211;
    phy_ctrl <= 8'h00;
    phy_err <= 8'h04;
    cyc(2);
    `CHK(xgpc_if_i.rx_bus, lanes(64'h8877_6655_44FE_2211, 8'h04))
    cyc(1);
    `CHK(rx_err_vec, 6'h01)
    `CHK(rx_data, 64'h8877_6655_44FE_2211)
    @(posedge sys_clk);
    phy_err <= 8'h00;
    cyc(3);
    `CHK(rx_err_vec, 6'h00)
    `CHK({rx_valid, rx_data}, {1'b1, 64'h8877_6655_4433_2211})
  endtask

  task automatic t_fault;
    for (int f = 1; f <= 2; f++)
    begin
      @(posedge sys_clk);
      phy_ctrl <= 8'h01;
      phy_data <= {32'h0, f[7:0], 16'h0, XGPC_CH_SEQ};
      cyc(5);
      `CHK({rx_fault, xgpc_if_i.fault_from_rx}, {f[1:0], f[1:0]})
      `CHK(tx_fault_seen, f[1:0])
      `CHK({xgpc_if_i.tx_bus[35:27], xgpc_if_i.tx_bus[8:0]}, 18'h0059C)
      @(posedge sys_clk);
      phy_ctrl <= (f == 2) ? 8'h01 : 8'h00;
      phy_data[7:0] <= XGPC_CH_START;
      cyc(5);
      `CHK(xgpc_if_i.fault_from_rx, XGPC_FLT_NONE)
    end
    for (int f = 2; f >= 0; f--)
    begin
      @(posedge sys_clk);
      fault_drive <= f[1:0];
      tx_fault_ext_en <= 1'b1;
      cyc(4);
      `CHK({tx_fault_seen, xgpc_if_i.fault_to_tx}, {f[1:0], f[1:0]})
    end
    @(posedge sys_clk);
    tx_fault_ext_en <= 1'b0;
    phy_ctrl <= 8'hFF;
    phy_data <= {8{XGPC_CH_IDLE}};
  endtask

  task automatic t_cfg;
    cfg_acc(1'b1, 13'h0005, 32'hA5C3_0F96);
    cfg_acc(1'b1, 13'h000F, 32'h1234_5678);
    cfg_acc(1'b1, 13'h0015, 32'hFFFF_FFFF);
    cfg_acc(1'b0, 13'h0005, 32'h0);
    `CHK(rd, 32'hA5C3_0F96)
    cfg_acc(1'b0, 13'h000F, 32'h0);
    `CHK(rd, 32'h1234_5678)
    cfg_acc(1'b0, 13'h0000, 32'h0);
    `CHK(rd, XGPC_CFG_RESET)
    cfg_acc(1'b0, 13'h1FFF, 32'h0);
    `CHK(rd, XGPC_UNMAPPED)
  endtask

  initial
  begin
    srst = 1'b1;
    {tx_valid, tx_sop, tx_eop, tx_err, tx_fault_ext_en, cmd_go, cmd_wr} = 7'h0;
    {tx_data, cmd_addr, cmd_wdata, fault_drive, phy_err} = '0;
    phy_data = {8{XGPC_CH_IDLE}};
    phy_ctrl = 8'hFF;
    n_fail = 0;
    n_checks = 0;
    repeat (5) @(posedge sys_clk);
    srst <= 1'b0;
    cyc(1);
    `CHK({xgpc_if_i.tx_bus, xgpc_if_i.cfg_wait}, {{8{9'h107}}, 1'b1})
    t_tx();
    t_rx();
    t_fault();
    t_cfg();
    give_verdict();
  end
endmodule
`default_nettype wire
